// ===== src/csp_pkg.sv
// Purpose: Shared constants for the codec serial port host controller.
// Assumes: 200 MHz system clock; 16-bit link words, most significant first.
// Notes: Register offsets are byte addresses on the Avalon-MM slave.
package csp_pkg;

  // System clock and derived timing
  localparam int CLK_MHZ = 200;
  localparam int CLK_HZ = CLK_MHZ * 1000000;
  localparam int LOCK_TIME_NS = 1000000;
  localparam int LOCK_CYC = (LOCK_TIME_NS * CLK_MHZ + 999) / 1000;
  localparam int STRAP_HOLD_NS = 100;
  localparam int STRAP_CYC = (STRAP_HOLD_NS * CLK_MHZ + 999) / 1000;
  localparam int FUP_MIN_HZ = 144000;
  localparam int MCLK_HALF_DEF = 12;

  // Link word layout
  localparam int WORD_BITS = 16;
  localparam int SEC_RW_BIT = 13;
  localparam int SEC_ADDR_LSB = 8;
  localparam int PRI_REQ_BIT = 0;

  // Device register addresses and fields
  localparam logic [4:0] DEV_CTRL2 = 5'h02;
  localparam logic [4:0] DEV_PLL_DIV = 5'h03;
  localparam logic [4:0] DEV_PLL_MUL = 5'h04;
  localparam int DEV_DIV10_BIT = 3;

  // Framing strap codes
  localparam logic [1:0] MODE_FRAMED = 2'h0;
  localparam logic [1:0] MODE_PULSE = 2'h1;
  localparam logic [1:0] MODE_SLAVE = 2'h2;
  localparam logic [1:0] MODE_RSVD = 2'h3;

  // Host register byte offsets
  localparam logic [4:0] OFS_CTRL = 5'h00;
  localparam logic [4:0] OFS_STATUS = 5'h04;
  localparam logic [4:0] OFS_TX = 5'h08;
  localparam logic [4:0] OFS_RX = 5'h0C;
  localparam logic [4:0] OFS_CMD = 5'h10;
  localparam logic [4:0] OFS_PLL = 5'h14;

  // Host register fields
  localparam int CTRL_RUN_BIT = 0;
  localparam int CTRL_MODE_LSB = 1;
  localparam int GO_BIT = 31;
  localparam int PLL_N_LSB = 0;
  localparam int PLL_M_LSB = 16;
  localparam int PLL_DIV10_BIT = 28;
  localparam int ST_CMD_BUSY = 0;
  localparam int ST_LOCK_BUSY = 1;
  localparam int ST_PLL_ERR = 2;
  localparam int ST_LINK_ON = 3;
  localparam int ST_RX_VALID = 4;

  // Secondary word builder
  function automatic logic [15:0] csp_sec_word(input logic rw,
      input logic [4:0] addr, input logic [7:0] data);
    return {2'b00, rw, addr, data};
  endfunction

endpackage : csp_pkg

// ===== src/csp_pin_sync.sv
// Purpose: Three-stage synchroniser for link pins with agreement filter.
// Assumes: Inputs are asynchronous to clk_i.
// Notes: Output changes once stages two and three agree.
module csp_pin_sync #(
  parameter int W = 4
) (
  input wire logic clk_i,
  input wire logic resetn_i,
  input wire logic [W-1:0] d_i,
  output logic [W-1:0] q_o
);
  logic [W-1:0] s1;
  logic [W-1:0] s2;
  logic [W-1:0] s3;

  // Shift chain and agreement filter
  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      s1 <= '0;
      s2 <= '0;
      s3 <= '0;
      q_o <= '0;
    end else begin
      s1 <= d_i;
      s2 <= s1;
      s3 <= s2;
      q_o <= (~(s2 ^ s3) & s2) | ((s2 ^ s3) & q_o);
    end
  end
endmodule // csp_pin_sync

// ===== src/csp_host.sv
// Purpose: Host controller driving a voiceband codec serial port and PLL.
// Assumes: Codec is bit-clock master in framing modes 0 and 1; in mode 2
//   the bit clock comes from the daisy-chain master on aux_bit_clk_i.
// Notes: Host samples serial_out on bit clock falls, drives on rises.
//
// The implementer's own choice: register access over Avalon-MM.
module csp_host
  import csp_pkg::*;
#(
  parameter int MCLK_HALF = csp_pkg::MCLK_HALF_DEF,
  parameter int LOCK_CYCLES = csp_pkg::LOCK_CYC
) (
  input wire logic clk_i,
  input wire logic resetn_i,
  input wire logic [4:0] avs_address_i,
  input wire logic avs_read_i,
  input wire logic avs_write_i,
  input wire logic [31:0] avs_writedata_i,
  input wire logic [3:0] avs_byteenable_i,
  output logic [31:0] avs_readdata_o,
  output logic avs_waitrequest_o,
  output logic mclk_o,
  output logic codec_reset_n_o,
  input wire logic sclk_i,
  output logic sclk_o,
  output logic sclk_oe_n_o,
  input wire logic serial_out_i,
  output logic serial_out_o,
  output logic serial_out_oe_n_o,
  input wire logic frame_sync_i,
  input wire logic aux_bit_clk_i,
  output logic serial_in_o
);
  import csp_pkg::*;

  typedef enum logic [5:0] {
    SQ_IDLE = 6'b000001,
    SQ_USER = 6'b000010,
    SQ_CTL = 6'b000100,
    SQ_DIV = 6'b001000,
    SQ_MUL = 6'b010000,
    SQ_LOCK = 6'b100000
  } csp_seq_e;

  localparam logic [31:0] MCLK_HZ = 32'(CLK_HZ / (2 * MCLK_HALF));
  localparam logic [31:0] N_MAX = MCLK_HZ / 32'(FUP_MIN_HZ);
  localparam logic [31:0] LOCK_LAST = 32'(LOCK_CYCLES - 1);
  localparam logic [7:0] STRAP_LAST = 8'(STRAP_CYC);
  localparam logic [7:0] MCLK_LAST = 8'(MCLK_HALF - 1);

  // Host registers and state
  logic ctrl_run;
  logic [1:0] ctrl_mode;
  logic [1:0] mode_lat;
  logic [14:0] tx_audio;
  logic [15:0] rx_audio;
  logic rx_valid;
  logic rx_new;
  logic [15:0] user_word;
  logic [7:0] cmd_rdata;
  logic [7:0] pll_div_m1;
  logic [7:0] pll_mul_m1;
  logic pll_div10;
  logic pll_err;
  csp_seq_e seq;
  logic cmd_pending;
  logic [15:0] cmd_word;
  logic [31:0] lock_cnt;
  logic [7:0] strap_cnt;
  logic [7:0] mclk_cnt;
  logic link_en;
  // Link state
  logic [3:0] sync_q;
  logic bit_clk_q;
  logic fs_q;
  logic armed;
  logic active;
  logic [3:0] bit_cnt;
  logic [15:0] rx_sh;
  logic [15:0] tx_sh;
  logic lk_done;
  logic cur_sec;
  logic req_sent;
  logic cmd_done;

  // Bus strobes and decode
  logic wr_fire;
  logic rd_fire;
  logic user_go;
  logic pll_go;
  logic pll_bad;
  logic [8:0] n_eff;
  logic [8:0] m_eff;
  logic [8:0] n_m1;
  logic [8:0] m_m1;
  logic bit_clk;
  logic bit_rise;
  logic bit_fall;
  logic start;
  logic [15:0] prim_word;

  assign wr_fire = avs_write_i && !avs_waitrequest_o && (&avs_byteenable_i);
  assign rd_fire = avs_read_i && !avs_waitrequest_o;
  assign user_go = wr_fire && avs_address_i == OFS_CMD
                   && avs_writedata_i[GO_BIT];
  assign pll_go = wr_fire && avs_address_i == OFS_PLL
                  && avs_writedata_i[GO_BIT];
  assign n_eff = avs_writedata_i[PLL_N_LSB +: 9];
  assign m_eff = avs_writedata_i[PLL_M_LSB +: 9];
  assign n_m1 = n_eff - 9'h001;
  assign m_m1 = m_eff - 9'h001;
  // Ratios 1..256 fit 8 bits; divider bounded by update rate
  assign pll_bad = n_eff == 9'h000 || m_eff == 9'h000
                   || n_eff > 9'h100 || m_eff > 9'h100
                   || {23'h0, n_eff} > N_MAX;

  // Link edge detection on filtered pins
  assign bit_clk = (mode_lat == MODE_SLAVE) ? sync_q[3] : sync_q[0];
  assign bit_rise = bit_clk && !bit_clk_q;
  assign bit_fall = !bit_clk && bit_clk_q;
  // Mode 1 starts one bit after the pulse, others on sync rise
  assign start = (mode_lat == MODE_PULSE) ? armed
                 : (sync_q[1] && !fs_q);
  assign prim_word = {tx_audio, cmd_pending};
  assign serial_in_o = tx_sh[15];

  // Pin synchroniser: clock, sync, data, aux clock
  csp_pin_sync #(.W(4)) u_sync (
    .clk_i(clk_i),
    .resetn_i(resetn_i),
    .d_i({aux_bit_clk_i, serial_out_i, frame_sync_i, sclk_i}),
    .q_o(sync_q)
  );

  // Avalon slave handshake: accept, then one low waitrequest cycle
  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      avs_waitrequest_o <= 1'b1;
      avs_readdata_o <= 32'h0;
    end else begin
      avs_waitrequest_o <= 1'b1;
      if ((avs_read_i || avs_write_i) && avs_waitrequest_o) begin
        avs_waitrequest_o <= 1'b0;
        unique case (avs_address_i)
          OFS_CTRL: avs_readdata_o <= {29'h0, ctrl_mode, ctrl_run};
          OFS_STATUS: avs_readdata_o <= {27'h0, rx_valid, link_en, pll_err,
              seq == SQ_LOCK, seq != SQ_IDLE && seq != SQ_LOCK};
          OFS_TX: avs_readdata_o <= {17'h0, tx_audio};
          OFS_RX: avs_readdata_o <= {16'h0, rx_audio};
          OFS_CMD: avs_readdata_o <= {16'h0, user_word[15:8], cmd_rdata};
          OFS_PLL: avs_readdata_o <= {3'h0, pll_div10, 3'h0,
              {1'b0, pll_mul_m1} + 9'h001, 7'h0,
              {1'b0, pll_div_m1} + 9'h001};
          default: avs_readdata_o <= 32'h0;
        endcase
      end
    end
  end

  // Software writable control registers
  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      ctrl_run <= 1'b0;
      ctrl_mode <= MODE_FRAMED;
      tx_audio <= 15'h0;
      user_word <= 16'h0;
      pll_div_m1 <= 8'h00;
      pll_mul_m1 <= 8'h00;
      pll_div10 <= 1'b0;
    end else if (wr_fire) begin
      unique case (avs_address_i)
        OFS_CTRL: begin
          ctrl_run <= avs_writedata_i[CTRL_RUN_BIT];
          ctrl_mode <= avs_writedata_i[CTRL_MODE_LSB +: 2];
        end
        OFS_TX: tx_audio <= avs_writedata_i[14:0];
        OFS_CMD: begin
          if (seq == SQ_IDLE) begin
            // One access: read/write bit, address, data
            user_word <= csp_sec_word(avs_writedata_i[SEC_RW_BIT],
                avs_writedata_i[SEC_ADDR_LSB +: 5],
                avs_writedata_i[7:0]);
          end
        end
        OFS_PLL: begin
          if (seq == SQ_IDLE && !pll_bad) begin
            pll_div_m1 <= n_m1[7:0];
            pll_mul_m1 <= m_m1[7:0];
            pll_div10 <= avs_writedata_i[PLL_DIV10_BIT];
          end
        end
        default: ;
      endcase
    end
  end

  // Receive-valid flag: a new sample beats the read clear
  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      rx_valid <= 1'b0;
    end else if (rx_new) begin
      rx_valid <= 1'b1;
    end else if (rd_fire && avs_address_i == OFS_RX) begin
      rx_valid <= 1'b0;
    end
  end

  // Master clock divider
  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      mclk_cnt <= 8'h00;
      mclk_o <= 1'b0;
    end else if (mclk_cnt == MCLK_LAST) begin
      mclk_cnt <= 8'h00;
      mclk_o <= !mclk_o;
    end else begin
      mclk_cnt <= mclk_cnt + 8'h01;
    end
  end

  // Codec reset and strap drive; mode latched while held in reset
  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      codec_reset_n_o <= 1'b0;
      mode_lat <= MODE_FRAMED;
      strap_cnt <= 8'h00;
      sclk_o <= 1'b0;
      serial_out_o <= 1'b0;
      sclk_oe_n_o <= 1'b0;
      serial_out_oe_n_o <= 1'b0;
      link_en <= 1'b0;
    end else if (!ctrl_run || ctrl_mode == MODE_RSVD) begin
      codec_reset_n_o <= 1'b0;
      mode_lat <= ctrl_mode;
      strap_cnt <= 8'h00;
      sclk_o <= ctrl_mode[1];
      serial_out_o <= ctrl_mode[0];
      sclk_oe_n_o <= 1'b0;
      serial_out_oe_n_o <= 1'b0;
      link_en <= 1'b0;
    end else begin
      codec_reset_n_o <= 1'b1;
      if (strap_cnt != STRAP_LAST) begin
        strap_cnt <= strap_cnt + 8'h01;
      end else begin
        // Slave mode keeps the clock pin strapped
        sclk_oe_n_o <= (mode_lat == MODE_SLAVE) ? 1'b0 : 1'b1;
        serial_out_oe_n_o <= 1'b1;
        link_en <= 1'b1;
      end
    end
  end

  // Bit engine: sample serial_out on bit clock falls
  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      bit_clk_q <= 1'b0;
      fs_q <= 1'b0;
      armed <= 1'b0;
      active <= 1'b0;
      bit_cnt <= 4'h0;
      rx_sh <= 16'h0;
      lk_done <= 1'b0;
    end else begin
      bit_clk_q <= bit_clk;
      lk_done <= 1'b0;
      if (!link_en) begin
        fs_q <= 1'b0;
        armed <= 1'b0;
        active <= 1'b0;
        bit_cnt <= 4'h0;
      end else if (bit_fall) begin
        fs_q <= sync_q[1];
        armed <= sync_q[1] && !active;
        if (active) begin
          rx_sh <= {rx_sh[14:0], sync_q[2]};
          bit_cnt <= bit_cnt + 4'h1;
          if (bit_cnt == 4'hF) begin
            active <= 1'b0;
            lk_done <= 1'b1;
          end
        end else if (start) begin
          rx_sh <= {rx_sh[14:0], sync_q[2]};
          bit_cnt <= 4'h1;
          active <= 1'b1;
        end
      end
    end
  end

  // Word engine: primary and secondary words, transmit shifter
  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      tx_sh <= 16'h0;
      cur_sec <= 1'b0;
      req_sent <= 1'b0;
      rx_audio <= 16'h0;
      rx_new <= 1'b0;
      cmd_rdata <= 8'h00;
      cmd_done <= 1'b0;
    end else begin
      rx_new <= 1'b0;
      cmd_done <= 1'b0;
      if (!link_en) begin
        cur_sec <= 1'b0;
        tx_sh <= prim_word;
        req_sent <= cmd_pending;
      end else if (lk_done && cur_sec) begin
        // Secondary done: low byte is read data
        cur_sec <= 1'b0;
        cmd_rdata <= rx_sh[7:0];
        cmd_done <= 1'b1;
        tx_sh <= {tx_audio, 1'b0};
        req_sent <= 1'b0;
      end else if (lk_done) begin
        // Primary done: audio out, secondary next if requested
        rx_audio <= (mode_lat == MODE_SLAVE)
                    ? {rx_sh[15:1], 1'b0} : rx_sh;
        rx_new <= 1'b1;
        if (req_sent) begin
          cur_sec <= 1'b1;
          tx_sh <= cmd_word;
        end else begin
          tx_sh <= prim_word;
          req_sent <= cmd_pending;
        end
      end else if (!active && !cur_sec) begin
        tx_sh <= prim_word;
        req_sent <= cmd_pending;
      end else if (active && bit_rise) begin
        tx_sh <= {tx_sh[14:0], 1'b0};
      end
    end
  end

  // Command sequencer: single access or PLL programming sequence
  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      seq <= SQ_IDLE;
      cmd_pending <= 1'b0;
      cmd_word <= 16'h0;
      lock_cnt <= 32'h0;
      pll_err <= 1'b0;
    end else begin
      unique case (seq)
        SQ_IDLE: begin
          if (user_go) begin
            cmd_word <= csp_sec_word(avs_writedata_i[SEC_RW_BIT],
                avs_writedata_i[SEC_ADDR_LSB +: 5],
                avs_writedata_i[7:0]);
            cmd_pending <= 1'b1;
            seq <= SQ_USER;
          end else if (pll_go && pll_bad) begin
            pll_err <= 1'b1;
          end else if (pll_go) begin
            pll_err <= 1'b0;
            cmd_word <= csp_sec_word(1'b0, DEV_CTRL2,
                {4'h0, avs_writedata_i[PLL_DIV10_BIT], 3'h0});
            cmd_pending <= 1'b1;
            seq <= SQ_CTL;
          end
        end
        SQ_USER: begin
          if (cmd_done) begin
            cmd_pending <= 1'b0;
            seq <= SQ_IDLE;
          end
        end
        SQ_CTL: begin
          if (cmd_done) begin
            cmd_word <= csp_sec_word(1'b0, DEV_PLL_DIV,
                pll_div_m1);
            seq <= SQ_DIV;
          end
        end
        SQ_DIV: begin
          if (cmd_done) begin
            cmd_word <= csp_sec_word(1'b0, DEV_PLL_MUL,
                pll_mul_m1);
            seq <= SQ_MUL;
          end
        end
        SQ_MUL: begin
          if (cmd_done) begin
            cmd_pending <= 1'b0;
            lock_cnt <= 32'h0;
            seq <= SQ_LOCK;
          end
        end
        SQ_LOCK: begin
          if (lock_cnt == LOCK_LAST) begin
            seq <= SQ_IDLE;
          end else begin
            lock_cnt <= lock_cnt + 32'h1;
          end
        end
      endcase
    end
  end
endmodule // csp_host

// ===== sim/csp_host_assertions.sv
// Purpose: Port-level checks for the codec serial host controller.
// Assumes: One clk_i domain, resetn_i asynchronous and active low.
// Notes: Bound into every csp_host instance at the foot of this file.
module csp_host_assertions #(
  parameter int MCLK_HALF = 12
) (
  input wire logic clk_i,
  input wire logic resetn_i,
  input wire logic avs_read_i,
  input wire logic avs_write_i,
  input wire logic [31:0] avs_readdata_o,
  input wire logic avs_waitrequest_o,
  input wire logic mclk_o,
  input wire logic codec_reset_n_o,
  input wire logic sclk_i,
  input wire logic sclk_o,
  input wire logic sclk_oe_n_o,
  input wire logic serial_out_oe_n_o,
  input wire logic frame_sync_i,
  input wire logic serial_in_o
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!resetn_i);
  logic mclk_q;
  logic seen;
  int unsigned cnt;
  logic sclk_q;
  logic [4:0] fall_cnt;
  // Bit clock falls seen while the frame sync is high
  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      sclk_q <= 1'b0;
      fall_cnt <= 5'h00;
    end else begin
      sclk_q <= sclk_i;
      if (!frame_sync_i) begin
        fall_cnt <= 5'h00;
      end else if (!sclk_i && sclk_q && fall_cnt != 5'h1F) begin
        fall_cnt <= fall_cnt + 5'h01;
      end
    end
  end
  // Cycles since the master clock last toggled
  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      mclk_q <= 1'b0;
      seen <= 1'b0;
      cnt <= 0;
    end else begin
      mclk_q <= mclk_o;
      seen <= seen | (mclk_o != mclk_q);
      cnt <= (mclk_o != mclk_q) ? 0 : cnt + 1;
    end
  end
  // Access steps and strap release steps
  sequence s_taken;
    (avs_read_i || avs_write_i) && avs_waitrequest_o;
  endsequence
  sequence s_answer;
    !avs_waitrequest_o ##1 avs_waitrequest_o;
  endsequence
  sequence s_strap_hold;
    !serial_out_oe_n_o [*8];
  endsequence
  chk_wait_answer: assert property (s_taken |=> s_answer)
    else $error("waitrequest not low for exactly one cycle");
  chk_wait_cause: assert property (
    !avs_waitrequest_o |-> $past(avs_read_i || avs_write_i))
    else $error("access ended without a request");
  chk_rdata_hold: assert property (
    !avs_waitrequest_o |=> $stable(avs_readdata_o))
    else $error("read data moved after the access");
  chk_straps_reset: assert property (
    !codec_reset_n_o && $past(!codec_reset_n_o)
    |-> !sclk_oe_n_o && !serial_out_oe_n_o)
    else $error("straps not driven while codec held in reset");
  chk_strap_release: assert property (
    $rose(codec_reset_n_o) |-> s_strap_hold ##[1:30] serial_out_oe_n_o)
    else $error("straps not held then released after codec reset");
  chk_sclk_owned: assert property (
    codec_reset_n_o && serial_out_oe_n_o |-> sclk_oe_n_o || sclk_o)
    else $error("host pulls the serial clock low while running");
  chk_sdi_edge: assert property (
    $changed(serial_in_o) && frame_sync_i && fall_cnt < 5'h10 |-> sclk_i)
    else $error("serial_in changed in the low clock phase");
  chk_mclk_rate: assert property (
    seen && mclk_o != mclk_q |-> cnt == MCLK_HALF - 1)
    else $error("master clock half period wrong");
  cov_access: cover property (s_taken ##1 s_answer);
endmodule // csp_host_assertions

bind csp_host csp_host_assertions #(.MCLK_HALF(MCLK_HALF)) u_chk (
  .clk_i(clk_i), .resetn_i(resetn_i), .avs_read_i(avs_read_i),
  .avs_write_i(avs_write_i), .avs_readdata_o(avs_readdata_o),
  .avs_waitrequest_o(avs_waitrequest_o), .mclk_o(mclk_o),
  .codec_reset_n_o(codec_reset_n_o), .sclk_i(sclk_i), .sclk_o(sclk_o),
  .sclk_oe_n_o(sclk_oe_n_o), .serial_out_oe_n_o(serial_out_oe_n_o),
  .frame_sync_i(frame_sync_i), .serial_in_o(serial_in_o));

// ===== sim/csp_codec_model.sv
// Purpose: Behavioural codec on the far side of the serial link.
// Assumes: Framed-word mode; 125 ns bit clock made here; board pulls low.
// Notes: Other framing modes latch their straps but stay quiet.
module csp_codec_model (
  input wire logic reset_n_i,
  input wire logic sclk_pin_i,
  input wire logic sdo_pin_i,
  input wire logic serial_in_i,
  input wire logic [15:0] pri_word_i,
  output logic sclk_o,
  output logic sclk_en_o,
  output logic serial_out_o,
  output logic serial_out_en_o,
  output logic frame_sync_o,
  output logic [1:0] mode_o,
  output logic [15:0] rx_pri_o,
  output logic [7:0] reg_ctl_o,
  output logic [7:0] reg_div_o,
  output logic [7:0] reg_mul_o,
  output logic order_ok_o
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [7:0] regs [32];
  logic [15:0] pw;
  logic [15:0] rs;
  logic [7:0] rd;
  logic sec;
  logic ins;
  logic [4:0] last_a;
  // Register view; both divider fields zero means PLL bypass
  assign reg_ctl_o = regs[2];
  assign reg_div_o = regs[3];
  assign reg_mul_o = regs[4];
  // One frame of 256 bit clocks: drive on rises, sample on falls
  task automatic frame();
    pw = pri_word_i;
    for (int b = 0; b < 256; b++) begin
      ins = sec && b >= 128 && b < 144;
      if (ins && b == 136) rd = rs[5] ? regs[rs[4:0]] : 8'h00;
      sclk_o = 1'b1;
      frame_sync_o = b < 16 || ins;
      serial_out_en_o = b < 16 || ins;
      if (b < 16) serial_out_o = pw[15 - b];
      else serial_out_o = ins && b >= 136 ? rd[143 - b] : 1'b0;
      #62.5;
      sclk_o = 1'b0;
      if (b < 16) rx_pri_o = {rx_pri_o[14:0], serial_in_i};
      if (ins) rs = {rs[14:0], serial_in_i};
      if (b == 15) sec = serial_in_i;
      if (ins && b == 143 && !rs[13]) begin
        regs[rs[12:8]] = rs[7:0];
        if (rs[12:8] == 5'h04) order_ok_o = last_a == 5'h03;
        last_a = rs[12:8];
      end
      if (b == 143) sec = 1'b0;
      #62.5;
    end
  endtask
  // Straps sampled and registers cleared while held in reset
  initial begin
    {sclk_o, sclk_en_o, serial_out_o, serial_out_en_o} = 4'h0;
    {frame_sync_o, order_ok_o, sec} = 3'h0;
    mode_o = 2'h0;
    rx_pri_o = 16'h0000;
    last_a = 5'h00;
    forever begin
      while (reset_n_i !== 1'b1) begin
        mode_o = {sclk_pin_i, sdo_pin_i};
        for (int i = 0; i < 32; i++) regs[i] = 8'h00;
        #5;
      end
      #200;
      sclk_en_o = mode_o == 2'h0;
      while (reset_n_i === 1'b1 && mode_o == 2'h0) frame();
      sclk_en_o = 1'b0;
      wait (reset_n_i !== 1'b1);
    end
  end
endmodule // csp_codec_model

// ===== sim/csp_host_bench.sv
// Purpose: Self-checking bench for the codec serial host controller.
// Assumes: Codec model on the link, board strap resistors pull low.
// Notes: Lock wait is shortened to keep the run brief.
module csp_host_bench;
  timeunit 1ns;
  timeprecision 1ps;
  import csp_pkg::*;
  logic clk_i, resetn_i, avs_read_i, avs_write_i;
  logic [4:0] avs_address_i;
  logic [31:0] avs_writedata_i, avs_readdata_o;
  logic [3:0] avs_byteenable_i;
  logic avs_waitrequest_o, mclk_o, codec_reset_n_o, sclk_o, sclk_oe_n_o;
  logic serial_out_o, serial_out_oe_n_o, serial_in_o;
  logic c_sclk, c_sclk_en, c_sdo, c_sdo_en, c_fs, c_ord;
  logic [1:0] c_mode;
  logic [15:0] c_rx, pri_word;
  logic [7:0] c_ctl, c_div, c_mul;
  int n_mismatch, cmp_count, seed;
  int dev_reg [32];
  // Pin levels from both ends, board pulls low when nobody drives
  wire logic sclk_w = !sclk_oe_n_o ? sclk_o : (c_sclk_en ? c_sclk : 1'b0);
  wire logic sdo_w = !serial_out_oe_n_o ? serial_out_o : c_sdo_en & c_sdo;
  csp_host #(.LOCK_CYCLES(50)) dut (.clk_i(clk_i), .resetn_i(resetn_i),
    .avs_address_i(avs_address_i), .avs_read_i(avs_read_i),
    .avs_write_i(avs_write_i), .avs_writedata_i(avs_writedata_i),
    .avs_byteenable_i(avs_byteenable_i), .avs_readdata_o(avs_readdata_o),
    .avs_waitrequest_o(avs_waitrequest_o), .mclk_o(mclk_o),
    .codec_reset_n_o(codec_reset_n_o), .sclk_i(sclk_w), .sclk_o(sclk_o),
    .sclk_oe_n_o(sclk_oe_n_o), .serial_out_i(sdo_w),
    .serial_out_o(serial_out_o), .serial_out_oe_n_o(serial_out_oe_n_o),
    .frame_sync_i(c_fs), .aux_bit_clk_i(1'b0), .serial_in_o(serial_in_o));
  csp_codec_model u_codec (.reset_n_i(codec_reset_n_o), .sclk_pin_i(sclk_w),
    .sdo_pin_i(sdo_w), .serial_in_i(serial_in_o), .pri_word_i(pri_word),
    .sclk_o(c_sclk), .sclk_en_o(c_sclk_en), .serial_out_o(c_sdo),
    .serial_out_en_o(c_sdo_en), .frame_sync_o(c_fs), .mode_o(c_mode),
    .rx_pri_o(c_rx), .reg_ctl_o(c_ctl), .reg_div_o(c_div),
    .reg_mul_o(c_mul), .order_ok_o(c_ord));
  // Counts and verdict, the single end of the run
  task automatic wrap_up();
    $display("Comparisons %0d, mismatches %0d", cmp_count, n_mismatch);
    if (n_mismatch == 0 && cmp_count > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask
  task automatic check(input string what, input logic [31:0] exp,
      input logic [31:0] got);
    cmp_count++;
    if (got !== exp) begin
      n_mismatch++;
      $display("[ERR] %s expected %h seen %h", what, exp, got);
    end
  endtask
  // One Avalon access held until waitrequest is sampled low
  task automatic bus(input logic wr, input logic [4:0] a,
      input logic [31:0] d, output logic [31:0] q);
    int n;
    @(posedge clk_i);
    avs_address_i <= a;
    avs_writedata_i <= d;
    avs_write_i <= wr;
    avs_read_i <= !wr;
    n = 0;
    do begin
      @(posedge clk_i);
      n++;
    end while (avs_waitrequest_o !== 1'b0 && n < 50);
    q = avs_readdata_o;
    avs_write_i <= 1'b0;
    avs_read_i <= 1'b0;
    check("bus answer", 0, {31'h0, avs_waitrequest_o});
    if (avs_waitrequest_o !== 1'b0) wrap_up();
  endtask
  // Read STATUS until the masked bits match, with a bound
  task automatic poll(input logic [31:0] m, input logic [31:0] want);
    logic [31:0] q;
    int n;
    n = 0;
    do begin
      bus(1'b0, OFS_STATUS, 32'h0, q);
      n++;
    end while ((q & m) !== want && n < 12000);
    check("status wait", want, q & m);
    if ((q & m) !== want) wrap_up();
  endtask
  task automatic cmd(input logic rw, input logic [4:0] a,
      input logic [7:0] d, output logic [31:0] q);
    bus(1'b1, OFS_CMD, 32'h8000_0000 | {18'h0, rw, a, d}, q);
    poll(32'h3, 32'h0);
    bus(1'b0, OFS_CMD, 32'h0, q);
  endtask
  // PLL request; bench model keeps ratio minus one when legal
  task automatic pll(input int n, input int m, input logic dten);
    logic [31:0] q;
    bus(1'b1, OFS_PLL, 32'h8000_0000 | (32'(dten) << PLL_DIV10_BIT) |
      (32'(m) << PLL_M_LSB) | 32'(n), q);
    poll(32'h3, 32'h0);
    if (n <= CLK_HZ / (2 * MCLK_HALF_DEF) / FUP_MIN_HZ) begin
      dev_reg[2] = dten ? (1 << DEV_DIV10_BIT) : 0;
      dev_reg[3] = n - 1;
      dev_reg[4] = m - 1;
    end
    check("ctl reg", dev_reg[2], {24'h0, c_ctl});
    check("div reg", dev_reg[3], {24'h0, c_div});
    check("mul reg", dev_reg[4], {24'h0, c_mul});
    check("pll order", 1, {31'h0, c_ord});
    bus(1'b0, OFS_STATUS, 32'h0, q);
    check("pll error", 32'(n > CLK_HZ / (2 * MCLK_HALF_DEF) / FUP_MIN_HZ),
      {31'h0, q[ST_PLL_ERR]});
    bus(1'b0, OFS_PLL, 32'h0, q);
    check("pll ratios", (32'(dev_reg[4] + 1) << PLL_M_LSB) |
      32'(dev_reg[3] + 1), q & 32'h01FF_01FF);
  endtask
  initial begin
    clk_i = 1'b0;
    forever #2.5 clk_i = ~clk_i;
  end
  initial begin
    logic [31:0] q;
    logic [14:0] audio;
    logic [7:0] d;
    {resetn_i, avs_read_i, avs_write_i} = 3'h0;
    avs_address_i = 5'h00;
    avs_writedata_i = 32'h0;
    avs_byteenable_i = 4'hF;
    pri_word = 16'h0000;
    {n_mismatch, cmp_count, seed} = {32'd0, 32'd0, 32'h1817};
    for (int i = 0; i < 32; i++) dev_reg[i] = 0;
    repeat (2) @(posedge clk_i);
    resetn_i <= 1'b1;
    // Each framing code reaches the strap pins
    for (int m = 0; m < 4; m++) begin
      bus(1'b1, OFS_CTRL, 32'(m) << CTRL_MODE_LSB, q);
      for (int n = 0; n < 40 && c_mode !== 2'(m); n++) @(posedge clk_i);
      check("strap mode", m, {30'h0, c_mode});
    end
    bus(1'b1, OFS_CTRL, 32'h7, q);
    repeat (30) @(posedge clk_i);
    check("reserved held", 0, {31'h0, codec_reset_n_o});
    check("div reset", 0, {24'h0, c_div});
    bus(1'b0, 5'h18, 32'h0, q);
    check("unmapped", 0, q);
    bus(1'b1, OFS_CTRL, 32'h0, q);
    bus(1'b1, OFS_CTRL, 32'h1, q);
    $display("test straps done");
    // Audio both ways; a partial write is ignored
    pri_word = 16'($random(seed));
    audio = 15'($random(seed));
    bus(1'b1, OFS_TX, {17'h0, audio}, q);
    avs_byteenable_i <= 4'h3;
    bus(1'b1, OFS_TX, {17'h0, ~audio}, q);
    avs_byteenable_i <= 4'hF;
    repeat (2) begin
      poll(32'h10, 32'h10);
      bus(1'b0, OFS_RX, 32'h0, q);
    end
    check("rx word", {16'h0, pri_word}, q);
    check("tx word", {16'h0, audio, 1'b0}, {16'h0, c_rx});
    $display("test primary done");
    pll(3, 10, 1'b1);
    pll(58, 10, 1'b0);
    $display("test pll done");
    // Secondary write then read back, and a divider read
    d = 8'($random(seed));
    cmd(1'b0, 5'h09, d, q);
    cmd(1'b1, 5'h09, 8'h00, q);
    check("reg read", {24'h0, d}, {24'h0, q[7:0]});
    cmd(1'b1, DEV_PLL_DIV, 8'h00, q);
    check("div read", dev_reg[3], {24'h0, q[7:0]});
    $display("test secondary done");
    wrap_up();
  end
endmodule // csp_host_bench
